// File: common/timpio_cfg.svh
// Purpose: constants for the timer pin function control block
// Assumes: 32-bit AHB-Lite register slave, one aligned word per register
// Notes: offsets are byte addresses within the slave's window
// Functional notes
// - bit7=1 selects input capture; bit6 ignored; bits5:4=00 capture on rising edge
// - capture mode with bits5:4=01 captures only on falling pin edge
// - capture mode with bit5=1 captures on both edges, bit4 ignored
// - bit7=0 is compare; bit6 initial level; 01 drives low on match, 00 retains
// - compare with bits5:4=10 drives initial level, then high on each match
// - compare with bits5:4=11 drives initial level, then toggles on each match
// - after reset each pin outputs low until its control register is first written
// - ch3 buffer bit set disables the ch3 D field: no capture, no compare events
`ifndef TIMPIO_CFG_SVH
`define TIMPIO_CFG_SVH

`define TIMPIO_ADDR_W 8
`define TIMPIO_CTL_BASE 8'h00
`define TIMPIO_GEN_BASE 8'h10
`define TIMPIO_MODE3_OFS 8'h20
`define TIMPIO_STATUS_OFS 8'h24
`define TIMPIO_MASK_OFS 8'h28
`define TIMPIO_FLD_MSB 7
`define TIMPIO_FLD_LSB 4
`define TIMPIO_BFB_BIT 5
`define TIMPIO_NUM_UNITS 4
`define TIMPIO_BUF_UNIT 2
`define TIMPIO_CTL_RST 4'h0
`define TIMPIO_GEN_RST 16'hffff
`define TIMPIO_COUNT_W 16
`define TIMPIO_HSIZE_WORD 3'h2

`endif

// File: common/timpio_pkg.sv
// Purpose: shared types of the timer pin function control block
// Assumes: field layout is bits 7:4 of each control register
// Notes: none
`default_nettype none
package timpio_pkg;

  typedef enum logic [1:0] {
    TIMPIO_ACT_RETAIN = 2'h0,
    TIMPIO_ACT_LOW = 2'h1,
    TIMPIO_ACT_HIGH = 2'h2,
    TIMPIO_ACT_TOGGLE = 2'h3
  } timpio_act_t;

  // one pin function field: capture select, initial level, action or edge code
  typedef struct packed {
    logic capture;
    logic init_level;
    timpio_act_t action;
  } timpio_field_t;

endpackage
`default_nettype wire

// File: rtl/timpio_sync.sv
// Purpose: two-flop synchroniser for the capture/compare pins
// Assumes: inputs are asynchronous to hclk
// Notes: only the second stage leaves the module
`timescale 1ns/1ns
`default_nettype none
module timpio_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule
`default_nettype wire

// File: rtl/timpio_unit.sv
// Purpose: one general register with its pin: capture or compare per field
// Assumes: count and control come from the hclk domain; pin_s is synchronised
// Notes: a capture takes priority over a software write of the general register
`timescale 1ns/1ns
`default_nettype none
`include "timpio_cfg.svh"
module timpio_unit #(
  parameter int CW = `TIMPIO_COUNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire timpio_pkg::timpio_field_t field,
  input wire logic field_wr,
  input wire timpio_pkg::timpio_field_t wr_field,
  input wire logic enable,
  input wire logic [CW-1:0] count,
  input wire logic pin_s,
  input wire logic sw_wr,
  input wire logic [CW-1:0] sw_data,
  output logic [CW-1:0] gen_reg,
  output logic pin_out,
  output logic pin_oe,
  output logic event_p
);

  logic written;
  logic pin_d;
  logic match_d;
  logic next_level;

  wire rise = pin_s & ~pin_d;
  wire fall = ~pin_s & pin_d;
  wire cap_edge = field.action[1] ? (rise | fall) : (field.action[0] ? fall : rise);
  wire cap_hit = enable & field.capture & cap_edge;
  wire match = (count == gen_reg);
  wire cmp_hit = enable & ~field.capture & match & ~match_d;

  always_comb
  begin
    next_level = pin_out;
    if (field_wr && !wr_field.capture && wr_field.action != timpio_pkg::TIMPIO_ACT_RETAIN)
      next_level = wr_field.init_level;
    else if (cmp_hit)
    begin
      case (field.action)
        timpio_pkg::TIMPIO_ACT_LOW: next_level = 1'b0;
        timpio_pkg::TIMPIO_ACT_HIGH: next_level = 1'b1;
        timpio_pkg::TIMPIO_ACT_TOGGLE: next_level = ~pin_out;
        default: next_level = pin_out;
      endcase
    end
  end

  // output driven low until the first field write
  assign pin_oe = ~(written & field.capture);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      written <= 1'b0;
      pin_d <= 1'b0;
      match_d <= 1'b0;
      pin_out <= 1'b0;
      gen_reg <= `TIMPIO_GEN_RST;
      event_p <= 1'b0;
    end
    else
    begin
      written <= written | field_wr;
      pin_d <= pin_s;
      match_d <= match;
      pin_out <= next_level;
      gen_reg <= cap_hit ? count : (sw_wr ? sw_data : gen_reg);
      event_p <= cap_hit | cmp_hit;
    end
  end

  property p_cap_load;
    @(posedge clk) disable iff (!rst_n) cap_hit |=> (gen_reg == $past(count)) && event_p;
  endproperty
  a_cap_load: assert property (p_cap_load) else $error("capture did not load counter");

  property p_rise_only;
    @(posedge clk) disable iff (!rst_n)
      (enable && field.capture && field.action == timpio_pkg::TIMPIO_ACT_RETAIN && rise) |=> event_p;
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("rising edge not captured");

  property p_fall_only;
    @(posedge clk) disable iff (!rst_n)
      (field.capture && field.action == timpio_pkg::TIMPIO_ACT_LOW && rise) |=> !event_p;
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("rising edge captured in falling mode");

  property p_both;
    @(posedge clk) disable iff (!rst_n) (enable && field.capture && field.action[1] && fall) |=> event_p;
  endproperty
  a_both: assert property (p_both) else $error("falling edge missed in both-edge mode");

  property p_low;
    @(posedge clk) disable iff (!rst_n)
      (cmp_hit && field.action == timpio_pkg::TIMPIO_ACT_LOW && !field_wr) |=> !pin_out && event_p;
  endproperty
  a_low: assert property (p_low) else $error("pin not low after match");

  property p_high;
    @(posedge clk) disable iff (!rst_n)
      (cmp_hit && field.action == timpio_pkg::TIMPIO_ACT_HIGH && !field_wr) |=> pin_out;
  endproperty
  a_high: assert property (p_high) else $error("pin not high after match");

  property p_toggle;
    @(posedge clk) disable iff (!rst_n)
      (cmp_hit && field.action == timpio_pkg::TIMPIO_ACT_TOGGLE && !field_wr) |=> pin_out != $past(pin_out);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin did not toggle on match");

  property p_init;
    @(posedge clk) disable iff (!rst_n)
      (field_wr && !wr_field.capture && wr_field.action != timpio_pkg::TIMPIO_ACT_RETAIN)
      |=> pin_out == $past(wr_field.init_level);
  endproperty
  a_init: assert property (p_init) else $error("initial level not driven");

  property p_reset_low;
    @(posedge clk) disable iff (!rst_n) !written |-> !pin_out && pin_oe;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("pin not low before first write");

endmodule
`default_nettype wire

// File: rtl/timpio_top.sv
// Purpose: AHB-Lite slave holding pin function fields for four timer pins
// Assumes: single word transfers; counters arrive from the hclk domain
// Notes: pin index 0 ch2 B, 1 ch3 B, 2 ch3 D, 3 ch4 B
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "timpio_cfg.svh"
module timpio_top #(
  parameter int CW = `TIMPIO_COUNT_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [CW-1:0] ch2_count,
  input wire logic [CW-1:0] ch3_count,
  input wire logic [CW-1:0] ch4_count,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe,
  output logic irq
);

  localparam int NU = `TIMPIO_NUM_UNITS;
  localparam int AW = `TIMPIO_ADDR_W;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic logic hit_word(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
    hit_word = (a == ofs);
  endfunction

  logic dp_valid;
  logic dp_write;
  logic dp_word;
  logic [AW-1:0] dp_addr;

  wire addr_phase = hsel & hready & htrans[1];
  wire wr_en = dp_valid & dp_write & dp_word;
  wire wr_mode3 = wr_en & hit_word(dp_addr, `TIMPIO_MODE3_OFS);
  wire wr_status = wr_en & hit_word(dp_addr, `TIMPIO_STATUS_OFS);
  wire wr_mask = wr_en & hit_word(dp_addr, `TIMPIO_MASK_OFS);
  wire timpio_pkg::timpio_field_t wr_field = hwdata[`TIMPIO_FLD_MSB:`TIMPIO_FLD_LSB];

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_word <= 1'b0;
      dp_addr <= '0;
    end
    else if (hready)
    begin
      dp_valid <= addr_phase;
      dp_write <= hwrite;
      dp_word <= (hsize == `TIMPIO_HSIZE_WORD) && (haddr[1:0] == 2'h0);
      dp_addr <= haddr[AW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control, mode, status and mask registers

  timpio_pkg::timpio_field_t ctl [NU];
  logic [CW-1:0] gen [NU];
  logic [NU-1:0] ctl_wr;
  logic [NU-1:0] gen_wr;
  logic [NU-1:0] evt;
  logic [NU-1:0] unit_en;
  logic [NU-1:0] pin_s;
  logic [NU-1:0] status;
  logic [NU-1:0] mask;
  logic bfb3;
  logic [CW-1:0] cnt [NU];

  assign cnt[0] = ch2_count;
  assign cnt[1] = ch3_count;
  assign cnt[2] = ch3_count;
  assign cnt[3] = ch4_count;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bfb3 <= 1'b0;
      mask <= '0;
      status <= '0;
    end
    else
    begin
      if (wr_mode3)
        bfb3 <= hwdata[`TIMPIO_BFB_BIT];
      if (wr_mask)
        mask <= hwdata[NU-1:0];
      // a new event wins over a same-cycle clear
      status <= (status & ~(wr_status ? hwdata[NU-1:0] : '0)) | evt;
    end
  end

  assign irq = |(status & mask);

  timpio_sync #(
    .W(NU)
  ) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d(pin_in),
    .q(pin_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // one unit per general register

  genvar gi;
  generate
    for (gi = 0; gi < NU; gi++)
    begin : g_unit
      localparam logic [AW-1:0] CTL_OFS = AW'(`TIMPIO_CTL_BASE + 4 * gi);
      localparam logic [AW-1:0] GEN_OFS = AW'(`TIMPIO_GEN_BASE + 4 * gi);

      assign ctl_wr[gi] = wr_en & hit_word(dp_addr, CTL_OFS);
      assign gen_wr[gi] = wr_en & hit_word(dp_addr, GEN_OFS);
      // the ch3 D field is dead while its register buffers B
      assign unit_en[gi] = (gi == `TIMPIO_BUF_UNIT) ? ~bfb3 : 1'b1;

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          ctl[gi] <= `TIMPIO_CTL_RST;
        else if (ctl_wr[gi])
          ctl[gi] <= wr_field;
      end

      timpio_unit #(
        .CW(CW)
      ) u_unit (
        .clk(hclk),
        .rst_n(hresetn),
        .field(ctl[gi]),
        .field_wr(ctl_wr[gi]),
        .wr_field(wr_field),
        .enable(unit_en[gi]),
        .count(cnt[gi]),
        .pin_s(pin_s[gi]),
        .sw_wr(gen_wr[gi]),
        .sw_data(hwdata[CW-1:0]),
        .gen_reg(gen[gi]),
        .pin_out(pin_out[gi]),
        .pin_oe(pin_oe[gi]),
        .event_p(evt[gi])
      );

      property p_ctl_load;
        @(posedge hclk) disable iff (!hresetn)
          ctl_wr[gi] |=> ctl[gi] == $past(wr_field);
      endproperty
      a_ctl_load: assert property (p_ctl_load) else $error("pin function field write not taken");

      // the pin is only released once its field selects capture
      property p_oe_capture_only;
        @(posedge hclk) disable iff (!hresetn)
          !pin_oe[gi] |-> ctl[gi].capture;
      endproperty
      a_oe_capture_only: assert property (p_oe_capture_only) else $error("pin released in compare mode");

      property p_gen_source;
        @(posedge hclk) disable iff (!hresetn)
          $changed(gen[gi]) |-> evt[gi] || $past(gen_wr[gi]);
      endproperty
      a_gen_source: assert property (p_gen_source) else $error("general register changed by itself");

      property p_read_ctl;
        @(posedge hclk) disable iff (!hresetn)
          (dp_valid && !dp_write && hit_word(dp_addr, CTL_OFS))
          |-> hrdata[`TIMPIO_FLD_MSB:`TIMPIO_FLD_LSB] == ctl[gi];
      endproperty
      a_read_ctl: assert property (p_read_ctl) else $error("pin function field read back wrong");

      property p_read_gen;
        @(posedge hclk) disable iff (!hresetn)
          (dp_valid && !dp_write && hit_word(dp_addr, GEN_OFS))
          |-> hrdata[CW-1:0] == gen[gi];
      endproperty
      a_read_gen: assert property (p_read_gen) else $error("general register read back wrong");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // read data, from registered address and register flops

  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (dp_valid && !dp_write)
    begin
      for (int i = 0; i < NU; i++)
      begin
        if (hit_word(dp_addr, AW'(`TIMPIO_CTL_BASE + 4 * i)))
          hrdata[`TIMPIO_FLD_MSB:`TIMPIO_FLD_LSB] = ctl[i];
        if (hit_word(dp_addr, AW'(`TIMPIO_GEN_BASE + 4 * i)))
          hrdata[CW-1:0] = gen[i];
      end
      if (hit_word(dp_addr, `TIMPIO_MODE3_OFS))
        hrdata[`TIMPIO_BFB_BIT] = bfb3;
      if (hit_word(dp_addr, `TIMPIO_STATUS_OFS))
        hrdata[NU-1:0] = status;
      if (hit_word(dp_addr, `TIMPIO_MASK_OFS))
        hrdata[NU-1:0] = mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  property p_buf_quiet;
    @(posedge hclk) disable iff (!hresetn) (bfb3 && $past(bfb3)) |-> !evt[`TIMPIO_BUF_UNIT];
  endproperty
  a_buf_quiet: assert property (p_buf_quiet) else $error("buffered D field raised an event");

  property p_flag_set;
    @(posedge hclk) disable iff (!hresetn) (evt != '0) |=> ((status & $past(evt)) == $past(evt));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event did not set status flag");

  property p_irq;
    @(posedge hclk) disable iff (!hresetn) irq == ((status & mask) != '0);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt disagrees with status and mask");

  property p_pin_low_after_reset;
    @(posedge hclk) disable iff (!hresetn) $rose(hresetn) |-> pin_out == 4'h0;
  endproperty
  a_pin_low_after_reset: assert property (p_pin_low_after_reset) else $error("pin high after reset");

  ////////////////////////////////////////////////////////////////////////////////
  // register and bus checks

  property p_status_clear;
    @(posedge hclk) disable iff (!hresetn)
      (wr_status && evt == '0) |=> status == ($past(status) & ~$past(hwdata[NU-1:0]));
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status bits not cleared by a one");

  // flags are sticky: only an event or a clear moves them
  property p_status_hold;
    @(posedge hclk) disable iff (!hresetn)
      (!wr_status && evt == '0) |=> $stable(status);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status moved with no event or clear");

  property p_irq_event;
    @(posedge hclk) disable iff (!hresetn)
      ((evt & mask) != '0 && !wr_mask) |=> irq;
  endproperty
  a_irq_event: assert property (p_irq_event) else $error("unmasked event did not raise interrupt");

  property p_mask_load;
    @(posedge hclk) disable iff (!hresetn)
      wr_mask |=> mask == $past(hwdata[NU-1:0]);
  endproperty
  a_mask_load: assert property (p_mask_load) else $error("mask write not taken");

  property p_mode_load;
    @(posedge hclk) disable iff (!hresetn)
      wr_mode3 |=> bfb3 == $past(hwdata[`TIMPIO_BFB_BIT]);
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("buffer select write not taken");

  // while buffering, only a field write may move the D pin
  property p_buf_pin_hold;
    @(posedge hclk) disable iff (!hresetn)
      ($past(bfb3) && !$past(ctl_wr[`TIMPIO_BUF_UNIT])) |-> $stable(pin_out[`TIMPIO_BUF_UNIT]);
  endproperty
  a_buf_pin_hold: assert property (p_buf_pin_hold) else $error("buffered D pin moved on a match");

  property p_addr_take;
    @(posedge hclk) disable iff (!hresetn)
      addr_phase |=> dp_valid && dp_addr == $past(haddr[AW-1:0]);
  endproperty
  a_addr_take: assert property (p_addr_take) else $error("address phase not registered");

  property p_write_no_data;
    @(posedge hclk) disable iff (!hresetn)
      (dp_valid && dp_write) |-> hrdata == 32'h0000_0000;
  endproperty
  a_write_no_data: assert property (p_write_no_data) else $error("read data driven during a write");

endmodule
`default_nettype wire

// File: sim/timpio_pins.sv
// Purpose: external circuitry on the four capture/compare pins
// Assumes: a pin not driven by the block follows the level set by the bench
// Notes: the pin level seen by the block is resolved here from both drivers
`timescale 1ns/1ns
`default_nettype none
module timpio_pins (
  input wire logic [3:0] ext_level,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  output logic [3:0] pin_in
);
  // the block wins where it drives, the outside circuit elsewhere
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Purpose: self-checking bench for the timer pin function control block
// Assumes: zero-wait AHB-Lite slave, word transfers only
// Notes: results are noted in a queue and compared by a separate monitor
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, rd_dp, smp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] ch2_count, ch3_count, ch4_count;
  logic [3:0] pin_in, pin_out, pin_oe, ext, lvl, oe, m;
  logic [31:0] q[$];
  int miscompares, tests_run;

  timpio_top u_timpio_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ch2_count(ch2_count), .ch3_count(ch3_count), .ch4_count(ch4_count),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
  timpio_pins u_timpio_pins (.ext_level(ext), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    hclk = 0;
    forever #2 hclk = ~hclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic complete_run;
    $display("tests %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one data-phase edge or one output sample per queued note
  always @(posedge hclk)
  begin
    logic [31:0] got;
    if ((rd_dp && hreadyout) || smp)
    begin
      got = rd_dp ? hrdata : {23'h0, irq, pin_oe, pin_out & pin_oe};
      tests_run++;
      if (q.size() == 0 || got !== q[0])
      begin
        miscompares++;
        $display("wrong value at %0t: got %h", $time, got);
      end
      if (q.size() != 0)
        void'(q.pop_front());
    end
  end

  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 9);
    if (hresp !== 1'b0)
    begin
      miscompares++;
      $display("wrong value at %0t: error response", $time);
    end
    if (n >= 9)
    begin
      miscompares++;
      complete_run;
    end
  endtask

  // write: d is written; read: d is the expected word
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    if (!wr)
    begin
      q.push_back(d);
      rd_dp <= 1'b1;
    end
    wait_ready();
    rd_dp <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] e);
    q.push_back(e);
    smp <= 1'b1;
    @(posedge hclk);
    smp <= 1'b0;
  endtask

  task automatic set_cnt(input int u, input logic [15:0] v);
    if (u == 0)
      ch2_count <= v;
    else if (u == 3)
      ch4_count <= v;
    else
      ch3_count <= v;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    hresetn = 0;
    hsel = 0;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hsize = 0;
    hwdata = 0;
    ch2_count = 0;
    ch3_count = 0;
    ch4_count = 0;
    ext = 0;
    rd_dp = 0;
    smp = 0;
    miscompares = 0;
    tests_run = 0;
    r = 32'hec47;
    lvl = 0;
    oe = 4'hf;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    chk({23'h0, 1'b0, 4'hf, 4'h0});
    for (int u = 0; u < 4; u++)
      bus(0, 8'(4 * u), 32'h0);
    bus(0, 8'h10, 32'hffff);
    bus(0, 8'h30, 32'h0);
    $display("reset and map test done");
    // every compare code on every unit, random interrupt mask
    for (int u = 0; u < 4; u++)
      for (int c = 0; c < 8; c++)
      begin
        r = xs(r);
        m = r[3:0];
        bus(1, 8'h28, {28'h0, m});
        bus(1, 8'(8'h10 + 4 * u), 32'(20 + u));
        bus(1, 8'(4 * u), {24'h0, 2'b00, c[2:0], 3'h0} << 1);
        if (c[1:0] != 2'h0)
          lvl[u] = c[2];
        chk({23'h0, 1'b0, 4'hf, lvl});
        bus(0, 8'(4 * u), {24'h0, 2'b00, c[2:0], 3'h0} << 1);
        set_cnt(u, 16'(20 + u));
        @(posedge hclk);
        set_cnt(u, 16'h0);
        repeat (4) @(posedge hclk);
        if (c[1:0] == 2'h1)
          lvl[u] = 1'b0;
        else if (c[1:0] == 2'h2)
          lvl[u] = 1'b1;
        else if (c[1:0] == 2'h3)
          lvl[u] = ~lvl[u];
        chk({23'h0, m[u], 4'hf, lvl});
        bus(0, 8'h24, 32'(1 << u));
        bus(1, 8'h24, 32'hf);
        bus(0, 8'h24, 32'h0);
      end
    $display("compare test done");
    // capture codes: unit u uses edge code u
    bus(1, 8'h28, 32'h0);
    for (int u = 0; u < 4; u++)
    begin
      r = xs(r);
      bus(1, 8'(4 * u), {24'h0, 1'b1, r[0], 2'(u), 4'h0});
      oe[u] = 1'b0;
      repeat (6) @(posedge hclk);
      bus(1, 8'h24, 32'hf);
      chk({23'h0, 1'b0, oe, lvl & oe});
      set_cnt(u, 16'(16'h100 + u));
      ext[u] <= 1'b1;
      repeat (6) @(posedge hclk);
      bus(0, 8'h24, u != 1 ? 32'(1 << u) : 32'h0);
      bus(1, 8'h24, 32'hf);
      set_cnt(u, 16'(16'h200 + u));
      ext[u] <= 1'b0;
      repeat (6) @(posedge hclk);
      bus(0, 8'h24, u != 0 ? 32'(1 << u) : 32'h0);
      bus(1, 8'h24, 32'hf);
      bus(0, 8'(8'h10 + 4 * u), u == 0 ? 32'h100 : 32'(16'h200 + u));
    end
    $display("capture test done");
    // buffer select silences the ch3 D unit
    bus(1, 8'h20, 32'h20);
    bus(0, 8'h20, 32'h20);
    ext[2] <= 1'b1;
    repeat (6) @(posedge hclk);
    ext[2] <= 1'b0;
    repeat (6) @(posedge hclk);
    bus(0, 8'h24, 32'h0);
    bus(1, 8'h20, 32'h0);
    ext[2] <= 1'b1;
    repeat (6) @(posedge hclk);
    bus(0, 8'h24, 32'h4);
    $display("buffer test done");
    complete_run();
  end

  initial
  begin
    repeat (50000) @(posedge hclk);
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
